// *** logic/lsbe_consts.vh ***
`ifndef LSBE_CONSTS_VH
`define LSBE_CONSTS_VH

// ****************************************
// operation codes on op_i
// ****************************************
`define LSBE_OP_OR_REG      4'h0
`define LSBE_OP_OR_IMM      4'h1
`define LSBE_OP_INV_BS      4'h2
`define LSBE_OP_OR_BS       4'h3
`define LSBE_OP_INV_OR_BS   4'h4
`define LSBE_OP_OUT_BYTE    4'h5
`define LSBE_OP_OUT_HALF    4'h6
`define LSBE_OP_OUT_WORD    4'h7
`define LSBE_OP_RET_EXC     4'h8
`define LSBE_OP_SAR_REG     4'h9
`define LSBE_OP_SAR_IMM     4'hA
`define LSBE_OP_SRCH0_DN    4'hB
`define LSBE_OP_SRCH1_UP    4'hC
`define LSBE_OP_SRCH1_DN    4'hD
`define LSBE_OP_SET_COND    4'hE
`define LSBE_OP_SHL_REG     4'hF

// ****************************************
// condition flag positions in the status word
// ****************************************
`define LSBE_FLG_ZERO   0
`define LSBE_FLG_SIGN   1
`define LSBE_FLG_WRAP   2
`define LSBE_FLG_CARRY  3

// ****************************************
// port sizes and address masks
// ****************************************
`define LSBE_SIZE_BYTE  2'h0
`define LSBE_SIZE_HALF  2'h1
`define LSBE_SIZE_WORD  2'h2
`define LSBE_MASK_HALF  32'hFFFFFFFE
`define LSBE_MASK_WORD  32'hFFFFFFFC

// ****************************************
// reset values
// ****************************************
`define LSBE_RST_WORD   32'h00000000
`define LSBE_RST_FLAGS  4'h0
`define LSBE_RST_SIZE   2'h0

`endif

// *** logic/lsbe_shifter.v ***
`include "lsbe_consts.vh"

// barrel shifter: left logical or right arithmetic, with carry out
module lsbe_shifter (
    input wire [31:0] val_i,
    input wire [4:0] cnt_i,
    input wire left_i,
    output reg [31:0] res_o,
    output reg carry_o
);
    reg [63:0] ext;
    reg [4:0] back;

    // arithmetic fill comes from the sign of the operand
    always @* begin
        ext = {{32{val_i[31]}}, val_i} >> cnt_i;
        back = 5'h0 - cnt_i;
        if (left_i) begin
            res_o = val_i << cnt_i;
        end else begin
            res_o = ext[31:0];
        end
        // last bit shifted out, zero count leaves carry clear
        if (cnt_i == 5'h00) begin
            carry_o = 1'b0;
        end else if (left_i) begin
            carry_o = val_i[back];
        end else begin
            carry_o = val_i[cnt_i - 5'h01];
        end
    end
endmodule

// *** logic/lsbe_bit_search.v ***
`include "lsbe_consts.vh"

// scans one word for the first bit equal to want_i
module lsbe_bit_search (
    input wire [31:0] word_i,
    input wire [4:0] start_i,
    input wire [31:0] len_i,
    input wire want_i,
    input wire down_i,
    output reg found_o,
    output reg [5:0] skip_o
);
    integer i;
    reg [4:0] pos;
    reg stop;

    // walk from start toward the word edge, bounded by remaining length
    always @* begin
        found_o = 1'b0;
        skip_o = 6'h00;
        stop = 1'b0;
        pos = start_i;
        for (i = 0; i < 32; i = i + 1) begin
            pos = down_i ? start_i - i[4:0] : start_i + i[4:0];
            if (!stop) begin
                if (i >= len_i || (down_i ? i > start_i
                                          : i > 31 - start_i)) begin
                    stop = 1'b1;
                end else if (word_i[pos] == want_i) begin
                    found_o = 1'b1;
                    stop = 1'b1;
                end else begin
                    skip_o = skip_o + 6'h01;
                end
            end
        end
    end
endmodule

// *** logic/lsbe_exec.v ***
`include "lsbe_consts.vh"

module lsbe_exec (
    input wire clk_i,
    input wire nrst_i,
    input wire start_i,
    input wire [3:0] op_i,
    input wire [31:0] reg1_val_i,
    input wire [31:0] reg2_val_i,
    input wire [15:0] imm16_i,
    input wire [4:0] imm5_i,
    input wire [3:0] flags_i,
    input wire [31:0] saved_pc_i,
    input wire [31:0] saved_psw_i,
    input wire [31:0] bs_src_i,
    input wire [31:0] bs_dst_i,
    input wire [31:0] bs_mask_i,
    input wire [31:0] srch_word_i,
    input wire [31:0] srch_addr_i,
    input wire [31:0] srch_len_i,
    output wire done_o,
    output wire [31:0] result_o,
    output wire result_we_o,
    output wire [3:0] flags_o,
    output wire flags_we_o,
    output wire [31:0] bs_word_o,
    output wire bs_we_o,
    output wire [31:0] port_addr_o,
    output wire [31:0] port_data_o,
    output wire [1:0] port_size_o,
    output wire port_we_o,
    output wire [31:0] pc_o,
    output wire [31:0] psw_o,
    output wire pc_load_o,
    output wire [31:0] srch_addr_o,
    output wire [31:0] srch_skip_o,
    output wire [31:0] srch_left_o,
    output wire srch_we_o
);

    // ****************************************
    // condition decode
    // ****************************************

    // low three bits pick a test, bit 3 inverts it
    function cond_true;
        input [3:0] cc;
        input [3:0] f;
        reg t;
        begin
            case (cc[2:0])
                3'h0: t = f[`LSBE_FLG_WRAP];
                3'h1: t = f[`LSBE_FLG_CARRY];
                3'h2: t = f[`LSBE_FLG_ZERO];
                3'h3: t = f[`LSBE_FLG_CARRY] | f[`LSBE_FLG_ZERO];
                3'h4: t = f[`LSBE_FLG_SIGN];
                3'h5: t = 1'b1;
                3'h6: t = f[`LSBE_FLG_SIGN] ^ f[`LSBE_FLG_WRAP];
                3'h7: t = (f[`LSBE_FLG_SIGN] ^ f[`LSBE_FLG_WRAP])
                          | f[`LSBE_FLG_ZERO];
                default: t = 1'b0;
            endcase
            cond_true = t ^ cc[3];
        end
    endfunction

    // logic result flags: carry kept, wrap cleared
    function [3:0] logic_flags;
        input [31:0] r;
        input [3:0] f;
        begin
            logic_flags = f;
            logic_flags[`LSBE_FLG_WRAP] = 1'b0;
            logic_flags[`LSBE_FLG_SIGN] = r[31];
            logic_flags[`LSBE_FLG_ZERO] = (r == 32'h00000000);
        end
    endfunction

    // ****************************************
    // operand shaping and helpers
    // ****************************************

    wire [31:0] disp_sext = {{16{imm16_i[15]}}, imm16_i};
    wire [31:0] raw_addr = reg1_val_i + disp_sext;
    wire [31:0] imm_zext = {16'h0000, imm16_i};
    wire is_shl = (op_i == `LSBE_OP_SHL_REG);
    wire is_imm_sar = (op_i == `LSBE_OP_SAR_IMM);
    // immediate count used zero-extended, register count low 5 bits
    wire [4:0] shift_cnt = is_imm_sar ? imm5_i
                                      : reg1_val_i[4:0];
    wire [31:0] shift_val = is_imm_sar ? reg2_val_i : reg2_val_i;
    wire [31:0] sh_res;
    wire sh_carry;
    wire srch_want = (op_i == `LSBE_OP_SRCH1_UP) ||
                     (op_i == `LSBE_OP_SRCH1_DN);
    wire srch_down = (op_i != `LSBE_OP_SRCH1_UP);
    wire srch_found;
    wire [5:0] srch_skip;

    lsbe_shifter u_shift (
        .val_i(shift_val),
        .cnt_i(shift_cnt),
        .left_i(is_shl),
        .res_o(sh_res),
        .carry_o(sh_carry)
    );

    lsbe_bit_search u_search (
        .word_i(srch_word_i),
        .start_i(srch_addr_i[4:0]),
        .len_i(srch_len_i),
        .want_i(srch_want),
        .down_i(srch_down),
        .found_o(srch_found),
        .skip_o(srch_skip)
    );

    // ****************************************
    // next-state registers
    // ****************************************

    reg done_ff, nxt_done;
    reg [31:0] result_ff, nxt_result;
    reg result_we_ff, nxt_result_we;
    reg [3:0] flags_ff, nxt_flags;
    reg flags_we_ff, nxt_flags_we;
    reg [31:0] bs_word_ff, nxt_bs_word;
    reg bs_we_ff, nxt_bs_we;
    reg [31:0] port_addr_ff, nxt_port_addr;
    reg [31:0] port_data_ff, nxt_port_data;
    reg [1:0] port_size_ff, nxt_port_size;
    reg port_we_ff, nxt_port_we;
    reg [31:0] pc_ff, nxt_pc;
    reg [31:0] psw_ff, nxt_psw;
    reg pc_load_ff, nxt_pc_load;
    reg [31:0] srch_addr_ff, nxt_srch_addr;
    reg [31:0] srch_skip_ff, nxt_srch_skip;
    reg [31:0] srch_left_ff, nxt_srch_left;
    reg srch_we_ff, nxt_srch_we;
    reg [31:0] bs_new;
    reg [31:0] step;

    // operation decode; write strobes are one-cycle pulses
    always @* begin
        nxt_done = start_i;
        nxt_result = result_ff;
        nxt_result_we = 1'b0;
        nxt_flags = flags_ff;
        nxt_flags_we = 1'b0;
        nxt_bs_word = bs_word_ff;
        nxt_bs_we = 1'b0;
        nxt_port_addr = port_addr_ff;
        nxt_port_data = port_data_ff;
        nxt_port_size = port_size_ff;
        nxt_port_we = 1'b0;
        nxt_pc = pc_ff;
        nxt_psw = psw_ff;
        nxt_pc_load = 1'b0;
        nxt_srch_addr = srch_addr_ff;
        nxt_srch_skip = srch_skip_ff;
        nxt_srch_left = srch_left_ff;
        nxt_srch_we = 1'b0;
        bs_new = bs_dst_i;
        step = {26'h0, srch_skip} + {31'h0, srch_found};
        if (start_i) begin
            case (op_i)
                `LSBE_OP_OR_REG: begin
                    nxt_result = reg1_val_i | reg2_val_i;
                    nxt_result_we = 1'b1;
                    nxt_flags = logic_flags(nxt_result, flags_i);
                    nxt_flags_we = 1'b1;
                end
                `LSBE_OP_OR_IMM: begin
                    nxt_result = reg1_val_i | imm_zext;
                    nxt_result_we = 1'b1;
                    nxt_flags = logic_flags(nxt_result, flags_i);
                    nxt_flags_we = 1'b1;
                end
                `LSBE_OP_INV_BS: begin
                    bs_new = ~bs_src_i;
                    nxt_bs_we = 1'b1;
                end
                `LSBE_OP_OR_BS: begin
                    bs_new = bs_src_i | bs_dst_i;
                    nxt_bs_we = 1'b1;
                end
                `LSBE_OP_INV_OR_BS: begin
                    bs_new = ~bs_src_i | bs_dst_i;
                    nxt_bs_we = 1'b1;
                end
                `LSBE_OP_OUT_BYTE: begin
                    nxt_port_addr = raw_addr;
                    nxt_port_data = {24'h000000, reg2_val_i[7:0]};
                    nxt_port_size = `LSBE_SIZE_BYTE;
                    nxt_port_we = 1'b1;
                end
                `LSBE_OP_OUT_HALF: begin
                    nxt_port_addr = raw_addr & `LSBE_MASK_HALF;
                    nxt_port_data = {16'h0000, reg2_val_i[15:0]};
                    nxt_port_size = `LSBE_SIZE_HALF;
                    nxt_port_we = 1'b1;
                end
                `LSBE_OP_OUT_WORD: begin
                    nxt_port_addr = raw_addr & `LSBE_MASK_WORD;
                    nxt_port_data = reg2_val_i;
                    nxt_port_size = `LSBE_SIZE_WORD;
                    nxt_port_we = 1'b1;
                end
                `LSBE_OP_RET_EXC: begin
                    nxt_pc = saved_pc_i;
                    nxt_psw = saved_psw_i;
                    nxt_pc_load = 1'b1;
                    nxt_flags = saved_psw_i[3:0];
                    nxt_flags_we = 1'b1;
                end
                `LSBE_OP_SAR_REG, `LSBE_OP_SAR_IMM,
                `LSBE_OP_SHL_REG: begin
                    nxt_result = sh_res;
                    nxt_result_we = 1'b1;
                    nxt_flags = logic_flags(sh_res, flags_i);
                    nxt_flags[`LSBE_FLG_CARRY] = sh_carry;
                    nxt_flags_we = 1'b1;
                end
                `LSBE_OP_SRCH0_DN, `LSBE_OP_SRCH1_UP,
                `LSBE_OP_SRCH1_DN: begin
                    // address moves past the hit
                    nxt_srch_addr = srch_down ? srch_addr_i - step
                                              : srch_addr_i + step;
                    nxt_srch_skip = {26'h0, srch_skip};
                    nxt_srch_left = srch_len_i - nxt_srch_skip;
                    nxt_srch_we = 1'b1;
                    if (op_i == `LSBE_OP_SRCH0_DN) begin
                        // zero flag tells software nothing was found
                        nxt_flags = flags_i;
                        nxt_flags[`LSBE_FLG_ZERO] = ~srch_found;
                        nxt_flags_we = 1'b1;
                    end
                end
                `LSBE_OP_SET_COND: begin
                    nxt_result = {31'h0,
                                  cond_true(imm5_i[3:0], flags_i)};
                    nxt_result_we = 1'b1;
                end
                default: begin
                    nxt_done = start_i;
                end
            endcase
            // only bits inside the string window are touched
            if (nxt_bs_we) begin
                nxt_bs_word = (bs_new & bs_mask_i)
                              | (bs_dst_i & ~bs_mask_i);
            end
        end
    end

    // ****************************************
    // state update
    // ****************************************

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_ff <= 1'b0;
            result_ff <= `LSBE_RST_WORD;
            result_we_ff <= 1'b0;
            flags_ff <= `LSBE_RST_FLAGS;
            flags_we_ff <= 1'b0;
            bs_word_ff <= `LSBE_RST_WORD;
            bs_we_ff <= 1'b0;
            port_addr_ff <= `LSBE_RST_WORD;
            port_data_ff <= `LSBE_RST_WORD;
            port_size_ff <= `LSBE_RST_SIZE;
            port_we_ff <= 1'b0;
            pc_ff <= `LSBE_RST_WORD;
            psw_ff <= `LSBE_RST_WORD;
            pc_load_ff <= 1'b0;
            srch_addr_ff <= `LSBE_RST_WORD;
            srch_skip_ff <= `LSBE_RST_WORD;
            srch_left_ff <= `LSBE_RST_WORD;
            srch_we_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
            result_ff <= nxt_result;
            result_we_ff <= nxt_result_we;
            flags_ff <= nxt_flags;
            flags_we_ff <= nxt_flags_we;
            bs_word_ff <= nxt_bs_word;
            bs_we_ff <= nxt_bs_we;
            port_addr_ff <= nxt_port_addr;
            port_data_ff <= nxt_port_data;
            port_size_ff <= nxt_port_size;
            port_we_ff <= nxt_port_we;
            pc_ff <= nxt_pc;
            psw_ff <= nxt_psw;
            pc_load_ff <= nxt_pc_load;
            srch_addr_ff <= nxt_srch_addr;
            srch_skip_ff <= nxt_srch_skip;
            srch_left_ff <= nxt_srch_left;
            srch_we_ff <= nxt_srch_we;
        end
    end

    // ****************************************
    // outputs, all straight from flip-flops
    // ****************************************

    assign done_o = done_ff;
    assign result_o = result_ff;
    assign result_we_o = result_we_ff;
    assign flags_o = flags_ff;
    assign flags_we_o = flags_we_ff;
    assign bs_word_o = bs_word_ff;
    assign bs_we_o = bs_we_ff;
    assign port_addr_o = port_addr_ff;
    assign port_data_o = port_data_ff;
    assign port_size_o = port_size_ff;
    assign port_we_o = port_we_ff;
    assign pc_o = pc_ff;
    assign psw_o = psw_ff;
    assign pc_load_o = pc_load_ff;
    assign srch_addr_o = srch_addr_ff;
    assign srch_skip_o = srch_skip_ff;
    assign srch_left_o = srch_left_ff;
    assign srch_we_o = srch_we_ff;
endmodule

// *** sim/lsbe_exec_assertions.sv ***
// ****************************************
// execute-stage answer checks
// ****************************************
module lsbe_exec_chk (
    input logic clk_i,
    input logic nrst_i,
    input logic start_i,
    input logic [3:0] op_i,
    input logic [31:0] reg1_val_i,
    input logic [31:0] reg2_val_i,
    input logic [15:0] imm16_i,
    input logic [3:0] flags_i,
    input logic [31:0] saved_pc_i,
    input logic [31:0] saved_psw_i,
    input logic [31:0] bs_src_i,
    input logic [31:0] bs_dst_i,
    input logic [31:0] bs_mask_i,
    input logic [31:0] srch_len_i,
    input logic [31:0] result_o,
    input logic result_we_o,
    input logic [3:0] flags_o,
    input logic flags_we_o,
    input logic [31:0] bs_word_o,
    input logic bs_we_o,
    input logic [31:0] port_addr_o,
    input logic [31:0] port_data_o,
    input logic [1:0] port_size_o,
    input logic port_we_o,
    input logic [31:0] pc_o,
    input logic [31:0] psw_o,
    input logic pc_load_o,
    input logic [31:0] srch_skip_o,
    input logic [31:0] srch_left_o,
    input logic srch_we_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // port address before the alignment mask
    logic [31:0] ea;
    assign ea = reg1_val_i + {{16{imm16_i[15]}}, imm16_i};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    AST_OR_REG: assert property (
        start_i && op_i == 4'h0 |=> result_we_o &&
        result_o == $past(reg1_val_i | reg2_val_i) && flags_o ==
        {$past(flags_i[3]), 1'b0, result_o[31], result_o == 32'h0})
        else $error("register or answer wrong");
    AST_INV_BS: assert property (
        start_i && op_i == 4'h2 |=> bs_we_o &&
        bs_word_o == $past(~bs_src_i & bs_mask_i | bs_dst_i & ~bs_mask_i))
        else $error("inverted string word wrong");
    AST_INV_OR_BS: assert property (
        start_i && op_i == 4'h4 |=> bs_we_o &&
        bs_word_o == $past(~bs_src_i & bs_mask_i | bs_dst_i))
        else $error("inverted or string word wrong");
    AST_OUT_HALF: assert property (
        start_i && op_i == 4'h6 |=> port_we_o && port_size_o == 2'h1 &&
        port_addr_o == ($past(ea) & 32'hFFFFFFFE) &&
        port_data_o == {16'h0, $past(reg2_val_i[15:0])})
        else $error("halfword port output wrong");
    AST_OUT_WORD: assert property (
        start_i && op_i == 4'h7 |=> port_we_o && port_size_o == 2'h2 &&
        port_addr_o == ($past(ea) & 32'hFFFFFFFC) &&
        port_data_o == $past(reg2_val_i))
        else $error("word port output wrong");
    AST_RETURN: assert property (
        start_i && op_i == 4'h8 |=> pc_load_o && flags_we_o &&
        pc_o == $past(saved_pc_i) && psw_o == $past(saved_psw_i) &&
        flags_o == $past(saved_psw_i[3:0]))
        else $error("return restore wrong");
    AST_SHL_ZERO: assert property (
        start_i && op_i == 4'hF && reg1_val_i[4:0] == 5'h0 |=>
        result_o == $past(reg2_val_i) && flags_o[3:2] == 2'h0)
        else $error("zero count shift wrong");
    AST_SEARCH: assert property (
        start_i && op_i inside {4'hB, 4'hC, 4'hD} |=> srch_we_o &&
        srch_left_o == $past(srch_len_i) - srch_skip_o)
        else $error("search remaining length wrong");
    AST_PORT_CAUSE: assert property (
        port_we_o |-> $past(start_i) && $past(op_i) inside {4'h5, 4'h6, 4'h7})
        else $error("port strobe without port op");
endmodule

bind lsbe_exec lsbe_exec_chk chk_u (.*);

// *** sim/lsbe_port_space.sv ***
// ****************************************
// port address space beyond the core
// ****************************************
module lsbe_port_space (
    input logic clk_i,
    input logic [31:0] addr_i,
    input logic [31:0] data_i,
    input logic we_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_writes = 0;
    logic [31:0] last_addr = 32'h0;
    logic [31:0] last_data = 32'h0;
    // one write per strobe; a stretched strobe shows as extra writes
    always @(posedge clk_i) begin
        if (we_i) begin
            last_addr <= addr_i;
            last_data <= data_i;
            n_writes <= n_writes + 1;
        end
    end
endmodule

// *** sim/lsbe_exec_tb_top.sv ***
// ****************************************
// execute stage bench
// ****************************************
module lsbe_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, nrst_i = 1'b0, start_i = 1'b0;
    logic [3:0] op_i = 4'h0, flags_i = 4'h0;
    logic [31:0] reg1_val_i = 32'h0, reg2_val_i = 32'h0;
    logic [31:0] saved_pc_i = 32'h0, saved_psw_i = 32'h0, bs_src_i = 32'h0;
    logic [31:0] bs_dst_i = 32'h0, bs_mask_i = 32'h0, srch_word_i = 32'h0;
    logic [31:0] srch_addr_i = 32'h0, srch_len_i = 32'h0;
    logic [15:0] imm16_i = 16'h0;
    logic [4:0] imm5_i = 5'h0;
    logic done_o, result_we_o, flags_we_o, bs_we_o, port_we_o, pc_load_o;
    logic srch_we_o;
    logic [3:0] flags_o;
    logic [1:0] port_size_o;
    logic [31:0] result_o, bs_word_o, port_addr_o, port_data_o, pc_o, psw_o;
    logic [31:0] srch_addr_o, srch_skip_o, srch_left_o;
    // operands of this step and expectation of the op in flight
    logic [31:0] v1, v2, vs, vd, vm, vpc, vpsw, p_r, p_a, p_k;
    logic [31:0] vw, va, vl;
    logic [15:0] i16;
    logic [4:0] i5;
    logic [3:0] vf, p_fl, p_fm, p_op;
    logic [5:0] p_stb;
    int p_sel, p_valid, fails, n_compared, n_ports, cond_fix;

    lsbe_exec dut_u (.*);
    lsbe_port_space port_u (.clk_i(clk_i), .addr_i(port_addr_o),
        .data_i(port_data_o), .we_i(port_we_o));

    // free-running core clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // reference behaviour of one start, worked from the operands
    task automatic model(input logic go, input logic [3:0] op);
        logic [4:0] n;
        logic [31:0] ea;
        logic hit;
        int lim, pos;
        logic dn;
        n = (op == 4'hA) ? i5 : v1[4:0];
        ea = v1 + {{16{i16[15]}}, i16};
        hit = 1'b0;
        p_op = op;
        p_sel = go ? 0 : 5;
        p_stb = go ? 6'h30 : 6'h00;
        p_r = 32'h0;
        if (go) begin
            case (op)
                4'h0: p_r = v1 | v2;
                4'h1: p_r = v1 | {16'h0, i16};
                4'h2, 4'h3, 4'h4: begin
                    p_r = (op == 4'h3) ? vs | vd : ~vs;
                    p_r = (op == 4'h4) ? p_r | vd : p_r;
                    p_r = (p_r & vm) | (vd & ~vm);
                    p_sel = 1;
                    p_stb = 6'h08;
                end
                4'h5, 4'h6, 4'h7: begin
                    p_r = (op == 4'h5) ? {24'h0, v2[7:0]} : v2;
                    p_r = (op == 4'h6) ? {16'h0, v2[15:0]} : p_r;
                    p_a = (op == 4'h5) ? ea : ea & 32'hFFFFFFFE;
                    p_a = (op == 4'h7) ? ea & 32'hFFFFFFFC : p_a;
                    p_sel = 2;
                    p_stb = 6'h04;
                    n_ports++;
                end
                4'h8: begin
                    p_r = vpc;
                    p_a = vpsw;
                    p_sel = 3;
                    p_stb = 6'h12;
                end
                4'h9, 4'hA: begin
                    p_r = $signed(v2) >>> n;
                    hit = (n != 0) ? v2[n - 1] : 1'b0;
                end
                4'hF: begin
                    p_r = v2 << n;
                    hit = (n != 0) ? v2[32 - n] : 1'b0;
                end
                4'hE: begin
                    case (i5[2:0])
                        3'h0: hit = vf[2];
                        3'h1: hit = vf[3];
                        3'h2: hit = vf[0];
                        3'h3: hit = vf[3] | vf[0];
                        3'h4: hit = vf[1];
                        3'h5: hit = 1'b1;
                        3'h6: hit = vf[1] ^ vf[2];
                        default: hit = (vf[1] ^ vf[2]) | vf[0];
                    endcase
                    p_r = {31'h0, hit ^ i5[3]};
                    p_stb = 6'h20;
                end
                default: begin
                    // scan bit by bit, bounded by length and word edge
                    dn = (op != 4'hC);
                    lim = dn ? va[4:0] + 1 : 32 - va[4:0];
                    lim = (vl < lim) ? vl : lim;
                    p_k = 32'h0;
                    for (int i = 0; i < lim && !hit; i++) begin
                        pos = dn ? va[4:0] - i : va[4:0] + i;
                        if (vw[pos] == (op != 4'hB))
                            hit = 1'b1;
                        else
                            p_k++;
                    end
                    p_r = dn ? va - p_k - hit : va + p_k + hit;
                    p_a = vl - p_k;
                    p_sel = 4;
                    p_stb = (op == 4'hB) ? 6'h11 : 6'h01;
                end
            endcase
        end
        p_fl = {(op < 4'h2) ? vf[3] : hit, 1'b0, p_r[31], p_r == 32'h0};
        p_fl = (op == 4'h8) ? vpsw[3:0] : p_fl;
        p_fl = (op == 4'hB) ? {vf[3:1], ~hit} : p_fl;
        p_fm = p_stb[4] ? 4'hF : 4'h0;
    endtask

    task automatic compare;
        check("strobes", 32'({result_we_o, flags_we_o, bs_we_o, port_we_o,
            pc_load_o, srch_we_o}), 32'(p_stb));
        check("done", 32'(done_o), 32'(p_stb != 6'h00));
        check("flags", 32'(flags_o & p_fm), 32'(p_fl & p_fm));
        case (p_sel)
            0: check("result", result_o, p_r);
            1: check("string word", bs_word_o, p_r);
            2: begin
                check("port address", port_addr_o, p_a);
                check("port data", port_data_o, p_r);
                check("port size", 32'(port_size_o), 32'(p_op - 4'h5));
            end
            3: check("status", psw_o, p_a);
            4: begin
                check("search address", srch_addr_o, p_r);
                check("search skip", srch_skip_o, p_k);
                check("search left", srch_left_o, p_a);
            end
            default: ;
        endcase
    endtask

    // one cycle: drive a start, then judge the previous one
    task automatic step(input logic go, input logic [3:0] op);
        @(posedge clk_i);
        v1 = $urandom;
        v2 = $urandom;
        vs = $urandom;
        vd = $urandom;
        vm = $urandom;
        vpc = $urandom;
        vpsw = $urandom;
        i16 = 16'($urandom);
        vf = 4'($urandom);
        i5 = 5'($urandom);
        vw = $urandom;
        va = $urandom;
        // short lengths so the length bound ends some scans
        vl = $urandom % 40;
        // counts of 0 and 31 are the corners of the shifter
        if ($urandom % 3 == 0)
            v1[4:0] = {5{v1[5]}};
        if (cond_fix >= 0)
            i5 = 5'(cond_fix);
        start_i <= go;
        op_i <= op;
        reg1_val_i <= v1;
        reg2_val_i <= v2;
        bs_src_i <= vs;
        bs_dst_i <= vd;
        bs_mask_i <= vm;
        saved_pc_i <= vpc;
        saved_psw_i <= vpsw;
        imm16_i <= i16;
        imm5_i <= i5;
        flags_i <= vf;
        srch_word_i <= vw;
        srch_addr_i <= va;
        srch_len_i <= vl;
        @(negedge clk_i);
        if (p_valid)
            compare;
        model(go, op);
        p_valid = 1;
    endtask

    task automatic reset_dut;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        start_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("reset result", result_o, 32'h0);
        check("reset outputs", 32'({done_o, port_we_o, flags_o}), 32'h0);
        nrst_i <= 1'b1;
        p_valid = 0;
    endtask

    // hang guard, far beyond the few hundred cycles of the run
    initial begin
        #200000;
        fails++;
        final_report;
    end

    initial begin
        void'($urandom(32'h3fd844ae));
        cond_fix = -1;
        reset_dut;
        for (int k = 0; k < 16; k++)
            step(1'b1, 4'(k));
        $display("test all op codes back to back done");
        for (int k = 0; k < 16; k++) begin
            cond_fix = k;
            step(1'b1, 4'hE);
        end
        cond_fix = -1;
        $display("test condition codes done");
        repeat (400) step($urandom % 8 != 0, 4'($urandom));
        step(1'b0, 4'h0);
        $display("test random ops done");
        reset_dut;
        repeat (60) step($urandom % 8 != 0, 4'($urandom));
        step(1'b0, 4'h0);
        step(1'b0, 4'h0);
        check("port writes", 32'(port_u.n_writes), 32'(n_ports));
        $display("test reset in mid run done");
        final_report;
    end
endmodule
